// ===== inc/qsc_defs.svh
// Purpose: Shared constants of the quad rate SRAM controller ports.
// Assumes: Core clock of 50 MHz.
// Notes: Widths follow the 36-bit datapath.
`ifndef QSC_DEFS_SVH
`define QSC_DEFS_SVH
`define QSC_ADDR_W 18
`define QSC_DATA_W 36
`define QSC_BE_W 4
`define QSC_LANE_W 9
`define QSC_DLY_W 6
`define QSC_DLY_TAPS 64
`define QSC_CLK_NS 20
`define QSC_TRAIN_TMO_NS 100000
`define QSC_TRAIN_ITER 5'h10
`define QSC_RD_LAT_EV 2'h2
`define QSC_BE_RST 4'hF
`endif

// ===== inc/qsc_pkg.sv
// Purpose: Types of the quad rate SRAM controller ports.
// Assumes: qsc_defs.svh on the include path.
// Notes: Requests travel as packed structs.
`include "qsc_defs.svh"
package qsc_pkg;
  typedef struct packed {
    logic [`QSC_ADDR_W-1:0] addr;
    logic [`QSC_DATA_W-1:0] data;
    logic [`QSC_BE_W-1:0] be_n;
  } qsc_wr_s;
  typedef struct packed {
    logic [`QSC_ADDR_W-1:0] addr;
    logic [`QSC_BE_W-1:0] be_n;
  } qsc_rd_s;
  typedef enum logic [1:0] {
    QSC_TRAIN = 2'b00,
    QSC_RUN = 2'b01,
    QSC_FAIL = 2'b10
  } qsc_state_e;
endpackage

// ===== verilog/qsc_ctrl.sv
// Purpose: Write and read bus ports in front of a quad rate SRAM.
// Assumes: Echo and capture clocks are sampled by core_clk.
// Notes: One memory command slot spans two core clocks.
//
// Local design decisions: the two-clock command slot and whole-clock echo delay steps.
`timescale 1ns/1ns
`default_nettype none
`include "qsc_defs.svh"

// ----------------------------------------
// Input synchroniser with agreement filter
// ----------------------------------------
module qsc_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A bit changes only once the second and third stages agree.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= (s2_r & s3_r) | (q & (s2_r ^ s3_r));
    end
  end
endmodule

// ----------------------------------------
// Echo delay line with tap edge detector
// ----------------------------------------
// The line only shifts in whole core clock steps; finer phase is not possible here.
module qsc_dly_tap #(
  parameter int TAPS = `QSC_DLY_TAPS,
  parameter int SEL_W = `QSC_DLY_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic d,
  input wire logic [SEL_W-1:0] sel,
  output logic rise
);
  logic [TAPS-1:0] line_r;
  logic tap_prev_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      line_r <= '0;
    end else begin
      line_r <= {line_r[TAPS-2:0], d};
    end
  end

  // The tap is registered as well, so each rising edge is seen exactly once.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tap_prev_r <= 1'b0;
    end else begin
      tap_prev_r <= line_r[sel];
    end
  end

  // Moving the tap while a read is pending can fake or lose one edge.
  always_comb begin
    rise = line_r[sel] & ~tap_prev_r;
  end
endmodule

// ----------------------------------------
// Controller
// ----------------------------------------
// Functional notes
// R1 - Core reset may assert anytime; its release is synchronous to the core clock.
// R2 - Raise training-done once read-capture training succeeds; accesses then proceed.
// R3 - Flag calibration failure when training exhausts iterations without aligning capture.
// R4 - Training seeks a rising edge on read bit 0; flag pattern missing otherwise.
// R5 - Byte enables on both ports are active low; zero enables the lane.
// R6 - Write wait refuses the write this cycle; master keeps presenting it.
// R7 - Read wait refuses the read this cycle; master retries later.
// R8 - Read data stands in the same cycle as its single valid pulse.
// R9 - Memory read select is active low and held high during reset.
// R10 - Memory write select is active low and held high during reset.
// R11 - In strobe mode a six-bit control sets echo clock delay shift.
// R12 - In non-strobe mode a separate capture clock captures read data.
// R13 - Write data width is configurable; read width matches it.
// R14 - A write is taken only with write select and write request high.
// R15 - A read is taken only with read select and read request high.
// R16 - Memory input clocks run continuously, regardless of transactions.
// R17 - Free-running echo clocks from memory time the read data capture.
// R18 - Datapath carries 36-bit data, 18-bit addresses, 4-bit active-low enables.
// R19 - A read and write arriving together: write served first, read deferred.
// R20 - Masters hold request fields stable while the port's wait stays high.
module qsc_ctrl
  import qsc_pkg::*;
#(
  parameter int TRAIN_TMO_CYC = `QSC_TRAIN_TMO_NS / `QSC_CLK_NS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_cs,
  input wire logic wr_req,
  input wire qsc_wr_s wr_cmd,
  output logic wr_wait,
  input wire logic rd_cs,
  input wire logic rd_req,
  input wire qsc_rd_s rd_cmd,
  output logic rd_wait,
  output logic [`QSC_DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic [`QSC_ADDR_W-1:0] mem_addr,
  output logic [`QSC_BE_W-1:0] mem_be_n,
  output logic [`QSC_DATA_W-1:0] mem_d,
  output logic mem_rd_sel_n,
  output logic mem_wr_sel_n,
  output logic mem_input_clock,
  output logic mem_input_clock_inv,
  input wire logic mem_echo_clock,
  input wire logic mem_echo_clock_inv,
  input wire logic [`QSC_DATA_W-1:0] mem_q,
  input wire logic strobe_mode,
  input wire logic [`QSC_DLY_W-1:0] delay_ctrl,
  input wire logic capture_clock,
  output logic training_done,
  output logic calibration_failed,
  output logic pattern_missing
);
  qsc_state_e state_r;
  logic kph_r;
  logic echo_f;
  logic echo_inv_f;
  logic cap_f;
  logic [`QSC_DATA_W-1:0] q_f;
  logic echo_rise;
  logic echo_inv_rise;
  logic cap_prev_r;
  logic cap_ev;
  logic wr_take;
  logic rd_take;
  logic trn_rd;
  logic rd_pend_r;
  logic [1:0] rd_cnt_r;
  logic [`QSC_BE_W-1:0] rd_be_r;
  logic [4:0] iter_r;
  logic have_prev_r;
  logic prev0_r;
  logic toggled_r;
  logic [31:0] tmo_r;

  // ----------------------------------------
  // Input sampling
  // ----------------------------------------
  qsc_sync #(.W(1)) u_sync_echo (.core_clk(core_clk), .rst(rst), .d(mem_echo_clock), .q(echo_f));
  qsc_sync #(.W(1)) u_sync_echo_inv (.core_clk(core_clk), .rst(rst), .d(mem_echo_clock_inv), .q(echo_inv_f));
  qsc_sync #(.W(1)) u_sync_cap (.core_clk(core_clk), .rst(rst), .d(capture_clock), .q(cap_f));
  qsc_sync #(.W(`QSC_DATA_W)) u_sync_q (.core_clk(core_clk), .rst(rst), .d(mem_q), .q(q_f));

  // ----------------------------------------
  // Echo delay line and capture events
  // ----------------------------------------
  qsc_dly_tap #(.TAPS(`QSC_DLY_TAPS), .SEL_W(`QSC_DLY_W)) u_tap_echo (
    .core_clk(core_clk),
    .rst(rst),
    .d(echo_f), // R17
    .sel(delay_ctrl), // R11
    .rise(echo_rise)
  );
  qsc_dly_tap #(.TAPS(`QSC_DLY_TAPS), .SEL_W(`QSC_DLY_W)) u_tap_echo_inv (
    .core_clk(core_clk),
    .rst(rst),
    .d(echo_inv_f), // R17
    .sel(delay_ctrl), // R11
    .rise(echo_inv_rise)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cap_prev_r <= 1'b0;
    end else begin
      cap_prev_r <= cap_f;
    end
  end

  always_comb begin
    if (strobe_mode) begin
      cap_ev = echo_rise | echo_inv_rise; // R11
    end else begin
      cap_ev = cap_f & ~cap_prev_r; // R12
    end
  end

  // ----------------------------------------
  // Memory clocks
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      kph_r <= 1'b0;
      mem_input_clock <= 1'b0;
      mem_input_clock_inv <= 1'b1;
    end else begin
      kph_r <= ~kph_r;
      mem_input_clock <= ~mem_input_clock; // R16
      mem_input_clock_inv <= ~mem_input_clock_inv; // R16
    end
  end

  // ----------------------------------------
  // Request acceptance
  // ----------------------------------------
  // Requests are taken only at the start of a slot, so the shared address bus never clashes.
  always_comb begin
    wr_wait = (state_r != QSC_RUN) | kph_r; // R6
    wr_take = wr_cs & wr_req & ~wr_wait; // R14
    rd_wait = (state_r != QSC_RUN) | kph_r | rd_pend_r | (wr_cs & wr_req); // R7 R19
    rd_take = rd_cs & rd_req & ~rd_wait; // R15
    trn_rd = (state_r == QSC_TRAIN) & ~kph_r;
  end

  // ----------------------------------------
  // Memory command slot
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_wr_sel_n <= 1'b1; // R10
      mem_rd_sel_n <= 1'b1; // R9
      mem_addr <= '0;
      mem_be_n <= `QSC_BE_RST;
      mem_d <= '0;
    end else if (!kph_r) begin
      mem_wr_sel_n <= ~wr_take; // R10
      mem_rd_sel_n <= ~(rd_take | trn_rd); // R9
      if (wr_take) begin
        mem_addr <= wr_cmd.addr; // R18 R19
        mem_be_n <= wr_cmd.be_n; // R5
        mem_d <= wr_cmd.data; // R13
      end else if (rd_take) begin
        mem_addr <= rd_cmd.addr;
        mem_be_n <= `QSC_BE_RST;
      end
    end
  end

  // ----------------------------------------
  // Read return
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_pend_r <= 1'b0;
      rd_cnt_r <= 2'h0;
      rd_be_r <= `QSC_BE_RST;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else begin
      rd_valid <= 1'b0;
      if (rd_take) begin
        rd_pend_r <= 1'b1;
        rd_cnt_r <= `QSC_RD_LAT_EV;
        rd_be_r <= rd_cmd.be_n;
      end else if (rd_pend_r && cap_ev) begin
        if (rd_cnt_r == 2'h1) begin
          rd_pend_r <= 1'b0;
          rd_valid <= 1'b1; // R8
          for (int i = 0; i < `QSC_BE_W; i++) begin
            rd_data[i*`QSC_LANE_W +: `QSC_LANE_W] <= rd_be_r[i] ? '0 : q_f[i*`QSC_LANE_W +: `QSC_LANE_W]; // R5 R8
          end
        end
        rd_cnt_r <= rd_cnt_r - 2'h1;
      end
    end
  end

  // ----------------------------------------
  // Training
  // ----------------------------------------
  // The timeout only runs in training, so a finished training never refires it.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tmo_r <= 32'h0;
    end else if (state_r == QSC_TRAIN) begin
      tmo_r <= tmo_r + 32'h1;
    end
  end

  // Reads issued during training return whatever the memory holds; bit 0 must rise from 0 to 1 between two captures.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= QSC_TRAIN;
      iter_r <= 5'h00;
      have_prev_r <= 1'b0;
      prev0_r <= 1'b0;
      toggled_r <= 1'b0;
      training_done <= 1'b0;
      calibration_failed <= 1'b0;
      pattern_missing <= 1'b0;
    end else begin
      unique case (state_r)
        QSC_TRAIN: begin
          if (cap_ev) begin
            have_prev_r <= 1'b1;
            prev0_r <= q_f[0];
            if (have_prev_r && (q_f[0] != prev0_r)) begin
              toggled_r <= 1'b1;
            end
            if (have_prev_r && !prev0_r && q_f[0]) begin
              state_r <= QSC_RUN;
              training_done <= 1'b1; // R2
            end else if (iter_r == `QSC_TRAIN_ITER - 5'h01) begin
              state_r <= QSC_FAIL;
              calibration_failed <= toggled_r; // R3
              pattern_missing <= ~toggled_r; // R4
            end else begin
              iter_r <= iter_r + 5'h01;
            end
          end else if (tmo_r == TRAIN_TMO_CYC[31:0]) begin
            state_r <= QSC_FAIL;
            pattern_missing <= 1'b1; // R4
          end
        end
        QSC_RUN: begin
          state_r <= QSC_RUN;
        end
        QSC_FAIL: begin
          state_r <= QSC_FAIL;
        end
        default: begin
          state_r <= QSC_FAIL;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== test/qsc_ctrl_assertions.sv
// Purpose: Port checks of the SRAM controller ports.
// Assumes: Bound to every qsc_ctrl instance.
// Notes: Reset disables every check.
`timescale 1ns/1ns
`default_nettype none
`include "qsc_defs.svh"
module qsc_ctrl_assertions
  import qsc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_cs,
  input wire logic wr_req,
  input wire qsc_wr_s wr_cmd,
  input wire logic wr_wait,
  input wire logic rd_cs,
  input wire logic rd_req,
  input wire logic rd_wait,
  input wire logic rd_valid,
  input wire logic [`QSC_ADDR_W-1:0] mem_addr,
  input wire logic [`QSC_DATA_W-1:0] mem_d,
  input wire logic [`QSC_BE_W-1:0] mem_be_n,
  input wire logic mem_wr_sel_n,
  input wire logic mem_input_clock,
  input wire logic mem_input_clock_inv,
  input wire logic training_done,
  input wire logic calibration_failed,
  input wire logic pattern_missing
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  chk_wr_issue: assert property (wr_cs && wr_req && !wr_wait |=>
    !mem_wr_sel_n && mem_addr == $past(wr_cmd.addr)) else $error("write not issued");
  chk_wr_payload: assert property (wr_cs && wr_req && !wr_wait |=>
    mem_d == $past(wr_cmd.data) && mem_be_n == $past(wr_cmd.be_n)) else $error("write payload wrong");
  chk_wr_cause: assert property ($fell(mem_wr_sel_n) |->
    $past(wr_cs) && $past(wr_req) && !$past(wr_wait)) else $error("write without request");
  chk_wr_two: assert property ($fell(mem_wr_sel_n) |=> !mem_wr_sel_n)
    else $error("write select too short");
  chk_wait_untrained: assert property (!training_done |-> wr_wait && rd_wait)
    else $error("access before training");
  chk_write_wins: assert property (wr_cs && wr_req && rd_cs && rd_req |-> rd_wait)
    else $error("read not deferred");
  chk_valid_pulse: assert property (rd_valid |=> !rd_valid)
    else $error("valid longer than one cycle");
  chk_clk_run: assert property (!rst |=> mem_input_clock == !$past(mem_input_clock)
    && mem_input_clock_inv == $past(mem_input_clock)) else $error("memory clock stalled");
  chk_flag_excl: assert property (training_done |-> !calibration_failed && !pattern_missing)
    else $error("failure flag with done");
endmodule
bind qsc_ctrl qsc_ctrl_assertions u_chk (.*);
`default_nettype wire

// ===== test/qsc_sram_model.sv
// Purpose: Behavioural quad rate SRAM behind the controller.
// Assumes: Commands are sampled on the memory input clock.
// Notes: Unwritten words return a slowly changing pattern.
`timescale 1ns/1ns
`default_nettype none
module qsc_sram_model (
  input wire logic mem_input_clock,
  input wire logic mem_rd_sel_n,
  input wire logic mem_wr_sel_n,
  input wire logic [17:0] mem_addr,
  input wire logic [3:0] mem_be_n,
  input wire logic [35:0] mem_d,
  output logic mem_echo_clock = 1'h0,
  output logic mem_echo_clock_inv,
  output logic [35:0] mem_q = 36'h0
);
  // Only the low address byte is kept; the bench stays inside that range.
  logic [35:0] mem [0:255];
  logic [255:0] wrt = '0;
  logic [35:0] w;
  int hold = 0;
  int nrd = 0;
  always #80 mem_echo_clock = ~mem_echo_clock;
  assign mem_echo_clock_inv = ~mem_echo_clock;
  // Commands launch on the same edge as the clock rise, so they are taken just after it.
  always @(posedge mem_input_clock) begin
    #1;
    w = wrt[mem_addr[7:0]] ? mem[mem_addr[7:0]] : 36'h0;
    if (!mem_wr_sel_n) begin
      for (int i = 0; i < 4; i++) if (!mem_be_n[i]) w[9*i +: 9] = mem_d[9*i +: 9];
      mem[mem_addr[7:0]] = w;
      wrt[mem_addr[7:0]] = 1'h1;
    end
    // Hold long enough to cover the widest echo delay, then scramble the bus.
    if (!mem_rd_sel_n) begin
      nrd++;
      mem_q <= wrt[mem_addr[7:0]] ? w : 36'(nrd >> 2);
      hold = 64;
    end else if (hold > 0) hold--;
    else mem_q <= ~mem_q;
  end
endmodule
`default_nettype wire

// ===== test/qsc_ctrl_tb.sv
// Purpose: Self-checking bench of the SRAM controller ports.
// Assumes: Training timeout shortened to 200 cycles.
// Notes: Capture clock follows the echo clock while cap_run is high.
`timescale 1ns/1ns
`default_nettype none
module qsc_ctrl_tb;
  import qsc_pkg::*;
  logic core_clk = 1'h0, rst = 1'h1, wr_cs = 1'h0, wr_req = 1'h0, rd_cs = 1'h0, rd_req = 1'h0;
  logic strobe_mode = 1'h1, capture_clock, wr_wait, rd_wait, rd_valid, mem_rd_sel_n, mem_wr_sel_n;
  logic mem_input_clock, mem_input_clock_inv, mem_echo_clock, mem_echo_clock_inv;
  logic training_done, calibration_failed, pattern_missing;
  logic cap_run = 1'h1;
  logic [5:0] delay_ctrl = 6'h01;
  logic [35:0] rd_data, mem_d, mem_q;
  logic [17:0] mem_addr;
  logic [3:0] mem_be_n;
  qsc_wr_s wr_cmd = '0;
  qsc_rd_s rd_cmd = '0;
  int fail_count = 0, n_checks = 0;
  assign capture_clock = mem_echo_clock & cap_run;
  always #10 core_clk = ~core_clk;
  qsc_ctrl #(.TRAIN_TMO_CYC(200)) dut (.*);
  qsc_sram_model mem_m (.*);
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [17:0] a, input logic [35:0] d, input logic [3:0] b);
    int n;
    wr_cs <= 1'h1;
    wr_req <= 1'h1;
    wr_cmd <= '{a, d, b};
    @(negedge core_clk);
    for (n = 0; n < 200 && wr_wait !== 1'h0; n++) @(negedge core_clk);
    check({35'h0, wr_wait}, 36'h0);
    @(posedge core_clk);
    wr_cs <= 1'h0;
    wr_req <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [17:0] a, input logic [3:0] b, input logic [35:0] e);
    int n;
    rd_cs <= 1'h1;
    rd_req <= 1'h1;
    rd_cmd <= '{a, b};
    @(negedge core_clk);
    for (n = 0; n < 200 && rd_wait !== 1'h0; n++) @(negedge core_clk);
    check({35'h0, rd_wait}, 36'h0);
    @(posedge core_clk);
    rd_cs <= 1'h0;
    rd_req <= 1'h0;
    for (n = 0; n < 400 && rd_valid !== 1'h1; n++) @(negedge core_clk);
    check({35'h0, rd_valid}, 36'h1);
    check(rd_data, e);
    @(posedge core_clk);
  endtask
  task automatic reset_and_train();
    int n;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check({34'h0, mem_wr_sel_n, mem_rd_sel_n}, 36'h3);
    @(posedge core_clk);
    rst <= 1'h0;
    for (n = 0; n < 2000 && training_done !== 1'h1; n++) @(negedge core_clk);
    check({33'h0, training_done, calibration_failed, pattern_missing}, 36'h4);
    @(posedge core_clk);
  endtask
  task automatic byte_lanes();
    wr(18'h00010, 36'h9ABCDEF12, 4'h0);
    wr(18'h00010, 36'h123456789, 4'hA);
    rd(18'h00010, 4'h0, 36'h9AB45EF89);
    rd(18'h00010, 4'h5, 36'h9A801EE00);
  endtask
  task automatic no_select();
    wr_req <= 1'h1;
    rd_req <= 1'h1;
    repeat (8) begin
      @(negedge core_clk);
      check({34'h0, mem_wr_sel_n, mem_rd_sel_n}, 36'h3);
    end
    @(posedge core_clk);
    wr_req <= 1'h0;
    rd_req <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic write_wins();
    fork
      wr(18'h00020, 36'h0F0F0F0F0, 4'h0);
      rd(18'h00010, 4'h0, 36'h9AB45EF89);
    join
  endtask
  task automatic capture_modes();
    for (int i = 0; i < 3; i++) begin
      strobe_mode <= (i < 2);
      delay_ctrl <= (i == 1) ? 6'h3F : 6'h00;
      @(posedge core_clk);
      rd(18'h00020, 4'h0, 36'h0F0F0F0F0);
    end
  endtask
  task automatic no_pattern();
    strobe_mode <= 1'h0;
    cap_run <= 1'h0;
    rst <= 1'h1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check({32'h0, mem_wr_sel_n, mem_rd_sel_n, wr_wait, rd_wait}, 36'hF);
    @(posedge core_clk);
    rst <= 1'h0;
    repeat (230) @(posedge core_clk);
    @(negedge core_clk);
    check({33'h0, training_done, calibration_failed, pattern_missing}, 36'h1);
    check({34'h0, wr_wait, rd_wait}, 36'h3);
  endtask
  initial begin
    #400000;
    fail_count++;
    complete_run();
  end
  initial begin
    reset_and_train();
    byte_lanes();
    no_select();
    write_wins();
    capture_modes();
    no_pattern();
    complete_run();
  end
endmodule
`default_nettype wire
